/* File: hdl/ssod_map.svh */
`ifndef SSOD_MAP_SVH
`define SSOD_MAP_SVH

// ==========================================
// Sizes
`define SSOD_NCH 8
`define SSOD_NPAIR 4
`define SSOD_FRAME_BITS 16
`define SSOD_CNT_W 10
`define SSOD_NSYNC 28

// ==========================================
// Register indices, shared by the serial command and the bus
`define SSOD_IDX_CTRL 3'h0
`define SSOD_IDX_DIAG_EN 3'h1
`define SSOD_IDX_FAULT_CLR 3'h2
`define SSOD_IDX_PAR 3'h3
`define SSOD_IDX_STATUS 3'h4
`define SSOD_IDX_OSM 3'h5
`define SSOD_IDX_LAST 3'h5

// ==========================================
// Bus byte offsets (index times four)
`define SSOD_OFS_CTRL 8'h00
`define SSOD_OFS_DIAG_EN 8'h04
`define SSOD_OFS_FAULT_CLR 8'h08
`define SSOD_OFS_PAR 8'h0c
`define SSOD_OFS_STATUS 8'h10
`define SSOD_OFS_OSM 8'h14

// ==========================================
// Serial command fields
`define SSOD_CMD_WR_BIT 15
`define SSOD_CMD_ADDR_HI 14
`define SSOD_CMD_ADDR_LO 12
`define SSOD_STAT_FAULT_HI 7
`define SSOD_STAT_OPEN_LOAD_OFF_SUMMARY_BIT 8
`define SSOD_STAT_TER_BIT 9

// ==========================================
// Reset values
`define SSOD_CTRL_RST 8'h00
`define SSOD_DIAG_EN_RST 8'h00
`define SSOD_PAR_RST 4'h0
`define SSOD_TER_RST 1'b1

`endif

/* File: hdl/ssod_pkg.sv */
package ssod_pkg;

  // ==========================================
  // Bus and pin bundles
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ssod_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ssod_apb_rsp_t;

  typedef struct packed {
    logic select_low;
    logic sclk;
    logic si;
  } ssod_pins_t;

  typedef struct packed {
    logic so_o;
    logic so_oe_n;
  } ssod_so_t;

  // Serial frame control
  typedef enum logic [1:0] {
    SSOD_IDLE,
    SSOD_SHIFT,
    SSOD_BLOCKED
  } ssod_state_t;

endpackage : ssod_pkg

/* File: hdl/ssod_sync.sv */
`timescale 1ns/1ps
// ==========================================
// Two-stage synchroniser bank
module ssod_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          meta[g] <= 1'b0;
          q[g] <= 1'b0;
        end else begin
          meta[g] <= d[g];
          q[g] <= meta[g];
        end
      end
    end
  endgenerate

endmodule : ssod_sync

/* File: hdl/ssod_top.sv */
`timescale 1ns/1ps
`include "ssod_map.svh"
// ==========================================
// Serial slave port with per-channel output diagnosis
module ssod_top (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire ssod_pkg::ssod_pins_t PINS,
  input wire logic SLEEP,
  input wire logic [`SSOD_NCH-1:0] OVERLOAD,
  input wire logic [`SSOD_NCH-1:0] OVERTEMP,
  input wire logic [`SSOD_NCH-1:0] OUT_ABOVE_THR,
  input wire ssod_pkg::ssod_apb_req_t APB_REQ,
  output ssod_pkg::ssod_apb_rsp_t APB_RSP,
  output ssod_pkg::ssod_so_t SO,
  output logic [`SSOD_NCH-1:0] CHAN_ON,
  output logic [`SSOD_NCH-1:0] DIAG_CUR_EN
);
  import ssod_pkg::*;

  // ==========================================
  // Input synchronisation
  logic [`SSOD_NSYNC-1:0] sync_in;
  logic [`SSOD_NSYNC-1:0] sync_out;
  logic select_low;
  logic sclk;
  logic si;
  logic sleep;
  logic [`SSOD_NCH-1:0] ovl;
  logic [`SSOD_NCH-1:0] ovt;
  logic [`SSOD_NCH-1:0] thr;

  // Select passes inverted: a cleared synchroniser then reads deselected, no false frame
  assign sync_in = {~PINS.select_low, PINS.sclk, PINS.si, SLEEP, OVERLOAD, OVERTEMP, OUT_ABOVE_THR};

  ssod_sync #(.W(`SSOD_NSYNC)) u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .d(sync_in),
    .q(sync_out)
  );

  assign {select_low, sclk, si, sleep, ovl, ovt, thr} = sync_out ^ {1'b1, {(`SSOD_NSYNC-1){1'b0}}};

  // ==========================================
  // Edge detection on synchronised pins
  logic select_low_d;
  logic sclk_d;
  logic sel_fall;
  logic sel_rise;
  logic sclk_fall;
  logic sclk_rise;

  // Select idles high after reset so no false frame start
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      select_low_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      select_low_d <= select_low;
      sclk_d <= sclk;
    end
  end

  assign sel_fall = select_low_d & ~select_low;
  assign sel_rise = ~select_low_d & select_low;
  assign sclk_fall = sclk_d & ~sclk;
  assign sclk_rise = ~sclk_d & sclk;

  // ==========================================
  // Register state
  ssod_state_t state;
  logic [`SSOD_FRAME_BITS-1:0] shift;
  logic [`SSOD_CNT_W-1:0] bit_cnt;
  logic cnt_ovf;
  logic frame_ok;
  logic frame_error_flag;
  logic [2:0] rd_idx;
  logic first_rise_seen;
  logic [`SSOD_NCH-1:0] ctrl;
  logic [`SSOD_NCH-1:0] diag_en;
  logic [`SSOD_NPAIR-1:0] par;
  logic [`SSOD_NCH-1:0] channel_fault_flag;
  logic [`SSOD_NCH-1:0] osm;
  logic open_load_off_summary;

  // ==========================================
  // Shared register read decode, bus and serial readback
  function automatic logic [15:0] reg_read(input logic [2:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    case (idx)
      `SSOD_IDX_CTRL: v = {8'h00, ctrl};
      `SSOD_IDX_DIAG_EN: v = {8'h00, diag_en};
      `SSOD_IDX_PAR: v = {12'h000, par};
      `SSOD_IDX_STATUS: v = {6'h00, frame_error_flag, open_load_off_summary, channel_fault_flag};
      `SSOD_IDX_OSM: v = {8'h00, thr};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : reg_read

  function automatic logic idx_mapped(input logic [2:0] idx);
    return idx <= `SSOD_IDX_LAST;
  endfunction : idx_mapped

  // ==========================================
  // Bus slave: zero wait states, ready one cycle after setup
  logic apb_setup;
  logic apb_done;
  logic apb_wr;
  logic apb_rd;
  logic [2:0] apb_idx;
  logic apb_hit;

  assign apb_setup = APB_REQ.psel & ~APB_REQ.penable;
  assign apb_done = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready;
  assign apb_idx = APB_REQ.paddr[4:2];
  assign apb_hit = (APB_REQ.paddr[7:5] == 3'h0) && (APB_REQ.paddr[1:0] == 2'h0) && idx_mapped(apb_idx);
  assign apb_wr = apb_done & APB_REQ.pwrite & ~APB_RSP.pslverr;
  assign apb_rd = apb_done & ~APB_REQ.pwrite & ~APB_RSP.pslverr;

  // Response flops; data captured at setup so the answer is registered
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      APB_RSP <= '0;
    end else if (apb_setup) begin
      APB_RSP.pready <= 1'b1;
      APB_RSP.pslverr <= ~apb_hit;
      APB_RSP.prdata <= (apb_hit && !APB_REQ.pwrite) ? {16'h0000, reg_read(apb_idx)} : 32'h0000_0000;
    end else begin
      APB_RSP.pready <= 1'b0;
      APB_RSP.pslverr <= 1'b0;
    end
  end

  // ==========================================
  // Serial frame sequencing
  logic spi_wr;
  logic [2:0] spi_idx;
  logic [7:0] spi_data;

  // Whole frames only: 16 bits plus up to 125 full bytes
  assign frame_ok = ~cnt_ovf && (bit_cnt >= `SSOD_CNT_W'(`SSOD_FRAME_BITS)) && (bit_cnt[2:0] == 3'h0);
  // Last 16 bits shifted in form this device's command
  assign spi_idx = shift[`SSOD_CMD_ADDR_HI:`SSOD_CMD_ADDR_LO];
  assign spi_data = shift[7:0];
  assign spi_wr = (state == SSOD_SHIFT) && sel_rise && frame_ok && shift[`SSOD_CMD_WR_BIT];

  // Frame state; sleep at select fall blocks the whole access
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state <= SSOD_IDLE;
    end else begin
      case (state)
        SSOD_IDLE: begin
          if (sel_fall) begin
            state <= sleep ? SSOD_BLOCKED : SSOD_SHIFT;
          end
        end
        SSOD_SHIFT: begin
          if (sel_rise) begin
            state <= SSOD_IDLE;
          end
        end
        SSOD_BLOCKED: begin
          if (sel_rise) begin
            state <= SSOD_IDLE;
          end
        end
        default: state <= SSOD_IDLE;
      endcase
    end
  end

  // Bit counter, wrapping past its top, with a sticky overflow flag
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      bit_cnt <= '0;
      cnt_ovf <= 1'b0;
    end else if (sel_fall) begin
      bit_cnt <= '0;
      cnt_ovf <= 1'b0;
    end else if (state == SSOD_SHIFT && sclk_fall) begin
      bit_cnt <= bit_cnt + `SSOD_CNT_W'(1);
      if (&bit_cnt) begin
        cnt_ovf <= 1'b1;
      end
    end
  end

  // Single shift register: load on select fall, sample input on clock fall
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      shift <= '0;
    end else if (sel_fall && !sleep) begin
      shift <= reg_read(rd_idx);
    end else if (state == SSOD_SHIFT && sclk_fall) begin
      shift <= {shift[`SSOD_FRAME_BITS-2:0], si};
    end
  end

  // Read request of an accepted frame picks the next readback word
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rd_idx <= `SSOD_IDX_STATUS;
    end else if ((state == SSOD_SHIFT) && sel_rise && frame_ok && !shift[`SSOD_CMD_WR_BIT]) begin
      rd_idx <= idx_mapped(spi_idx) ? spi_idx : `SSOD_IDX_STATUS;
    end
  end

  // Frame error: set on a bad count, cleared by the next good frame
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      frame_error_flag <= `SSOD_TER_RST;
    end else if ((state == SSOD_SHIFT) && sel_rise) begin
      frame_error_flag <= ~frame_ok;
    end
  end

  // ==========================================
  // Serial output driver
  // Until the first rising clock the output follows error OR input, so a
  // chain forwards an upstream error without waiting for data.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      SO.so_o <= 1'b0;
      SO.so_oe_n <= 1'b1;
      first_rise_seen <= 1'b0;
    end else if (state != SSOD_SHIFT || select_low) begin
      SO.so_o <= 1'b0;
      SO.so_oe_n <= 1'b1;
      first_rise_seen <= 1'b0;
    end else begin
      SO.so_oe_n <= 1'b0;
      if (sclk_rise) begin
        SO.so_o <= shift[`SSOD_FRAME_BITS-1];
        first_rise_seen <= 1'b1;
      end else if (!first_rise_seen) begin
        SO.so_o <= frame_error_flag | si;
      end
    end
  end

  // ==========================================
  // Writable configuration, serial writes take priority over the bus
  logic [7:0] apb_wbyte;
  assign apb_wbyte = APB_REQ.pwdata[7:0];

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl <= `SSOD_CTRL_RST;
      diag_en <= `SSOD_DIAG_EN_RST;
      par <= `SSOD_PAR_RST;
    end else if (spi_wr) begin
      if (spi_idx == `SSOD_IDX_CTRL) begin
        ctrl <= spi_data;
      end
      if (spi_idx == `SSOD_IDX_DIAG_EN) begin
        diag_en <= spi_data;
      end
      if (spi_idx == `SSOD_IDX_PAR) begin
        par <= spi_data[`SSOD_NPAIR-1:0];
      end
    end else if (apb_wr) begin
      if (apb_idx == `SSOD_IDX_CTRL) begin
        ctrl <= apb_wbyte;
      end
      if (apb_idx == `SSOD_IDX_DIAG_EN) begin
        diag_en <= apb_wbyte;
      end
      if (apb_idx == `SSOD_IDX_PAR) begin
        par <= apb_wbyte[`SSOD_NPAIR-1:0];
      end
    end
  end

  // ==========================================
  // Fault latching per channel; paired channels share events
  logic [`SSOD_NCH-1:0] fault_ev;
  logic [`SSOD_NCH-1:0] fault_clear_bit;

  genvar c;
  generate
    for (c = 0; c < `SSOD_NCH; c++) begin : g_ch
      // Only a paired partner can disturb this channel
      assign fault_ev[c] = ovl[c] | ovt[c] | (par[c/2] & (ovl[c^1] | ovt[c^1]));
    end
  endgenerate

  assign fault_clear_bit = (spi_wr && spi_idx == `SSOD_IDX_FAULT_CLR) ? spi_data :
                           (apb_wr && apb_idx == `SSOD_IDX_FAULT_CLR) ? apb_wbyte : 8'h00;

  // A new event in the clearing cycle keeps the flag set
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      channel_fault_flag <= '0;
    end else begin
      channel_fault_flag <= (channel_fault_flag & ~fault_clear_bit) | fault_ev;
    end
  end

  // ==========================================
  // Output status monitor snapshot, refreshed only on a bus or serial read of OSM
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      osm <= '0;
    end else if ((apb_rd && apb_idx == `SSOD_IDX_OSM) || (sel_fall && !sleep && rd_idx == `SSOD_IDX_OSM)) begin
      osm <= thr;
    end
  end

  // Summary only looks at off channels with current on; open load never
  // touches the channel enable.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      open_load_off_summary <= 1'b0;
    end else begin
      open_load_off_summary <= |(osm & ~CHAN_ON & diag_en);
    end
  end

  // ==========================================
  // Channel drive outputs
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      CHAN_ON <= '0;
      DIAG_CUR_EN <= '0;
    end else begin
      CHAN_ON <= ctrl & ~channel_fault_flag;
      DIAG_CUR_EN <= diag_en;
    end
  end

endmodule : ssod_top

/* File: verification/ssod_sva.sv */
`timescale 1ns/1ps
`include "ssod_map.svh"
// ====================
// Port checker
module ssod_chk (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire ssod_pkg::ssod_pins_t PINS,
  input wire logic SLEEP,
  input wire logic [`SSOD_NCH-1:0] OVERLOAD,
  input wire logic [`SSOD_NCH-1:0] OVERTEMP,
  input wire ssod_pkg::ssod_apb_req_t APB_REQ,
  input wire ssod_pkg::ssod_apb_rsp_t APB_RSP,
  input wire ssod_pkg::ssod_so_t SO,
  input wire logic [`SSOD_NCH-1:0] CHAN_ON,
  input wire logic [`SSOD_NCH-1:0] DIAG_CUR_EN
);
  import ssod_pkg::*;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic setup;
  logic unm;
  logic [7:0] ev;
  logic diag_wr;
  // Decoded bus phase and fault events
  assign setup = APB_REQ.psel && !APB_REQ.penable;
  assign unm = APB_REQ.paddr[7:5] != 3'h0 || APB_REQ.paddr[1:0] != 2'h0 || APB_REQ.paddr[4:2] > `SSOD_IDX_LAST;
  assign ev = OVERLOAD | OVERTEMP;
  assign diag_wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && APB_RSP.pready &&
    APB_REQ.paddr == `SSOD_OFS_DIAG_EN;
  // Select phases, long enough to cover the sync delay
  sequence sel_idle;
    PINS.select_low[*6];
  endsequence
  sequence sel_fall_awake;
    $fell(PINS.select_low) && !SLEEP ##1 (!PINS.select_low && !SLEEP)[*5];
  endsequence
  sequence sel_fall_asleep;
    (PINS.select_low && SLEEP)[*6] ##1 (!PINS.select_low && SLEEP)[*8];
  endsequence
  // Bus answers
  chk_ready_next: assert property (setup |=> APB_RSP.pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (APB_RSP.pready |=> !APB_RSP.pready)
    else $error("ready held too long");
  chk_err_map: assert property (setup |=> APB_RSP.pslverr == $past(unm))
    else $error("wrong error response");
  chk_err_data: assert property (setup && unm |=> APB_RSP.prdata == 32'h0)
    else $error("unmapped read not zero");
  // Serial output enable
  chk_idle_hiz: assert property (sel_idle |-> SO.so_oe_n)
    else $error("output driven while idle");
  chk_drive_on_sel: assert property (sel_fall_awake |-> !SO.so_oe_n)
    else $error("output not driven after select");
  chk_sleep_hiz: assert property (sel_fall_asleep |-> SO.so_oe_n)
    else $error("output driven in sleep");
  // Channel effects
  chk_fault_off: assert property ((ev != 8'h00 && $stable(ev))[*6] |-> (ev & CHAN_ON) == 8'h00)
    else $error("faulted channel still on");
  chk_diag_copy: assert property (diag_wr |=> ##1 DIAG_CUR_EN == $past(APB_REQ.pwdata[7:0], 2))
    else $error("diagnosis enable not applied");
endmodule : ssod_chk

bind ssod_top ssod_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .PINS(PINS), .SLEEP(SLEEP), .OVERLOAD(OVERLOAD),
  .OVERTEMP(OVERTEMP), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .SO(SO), .CHAN_ON(CHAN_ON),
  .DIAG_CUR_EN(DIAG_CUR_EN));

/* File: verification/ssod_host.sv */
`timescale 1ns/1ps
// ====================
// Host model driving select, clock and data
module ssod_host (
  input wire logic clk,
  output ssod_pkg::ssod_pins_t pins,
  input wire ssod_pkg::ssod_so_t so
);
  import ssod_pkg::*;
  // Undriven line reads inverted, so a missing enable corrupts the data seen
  logic so_line;
  assign so_line = so.so_oe_n ? ~so.so_o : so.so_o;
  // Idle: deselected, clock and data at pull-down level
  initial pins = 3'b100;
  // One frame, 8 cycles a bit; output read mid low phase
  task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] q, output logic pre,
      output logic oe);
    q = 32'h0;
    oe = 1'b0;
    @(posedge clk) pins <= {1'b0, 1'b0, d[n-1]};
    repeat (5) @(posedge clk);
    pre = so_line;
    for (int i = n - 1; i >= 0; i--) begin
      oe |= !so.so_oe_n;
      pins <= {1'b0, 1'b1, d[i]};
      repeat (4) @(posedge clk);
      pins.sclk <= 1'b0;
      repeat (3) @(posedge clk);
      q = {q[30:0], so_line};
      @(posedge clk);
    end
    pins <= 3'b100;
    repeat (6) @(posedge clk);
  endtask : xfer
endmodule : ssod_host

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import ssod_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sleep = 1'b0;
  logic [7:0] ovl = 8'h00, ovt = 8'h00, thr = 8'h00;
  logic [7:0] chan_on, diag_en;
  ssod_pins_t pins;
  ssod_apb_req_t req = '0;
  ssod_apb_rsp_t rsp;
  ssod_so_t so;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int bad_len[4] = '{8, 17, 23, 31};
  localparam int SETTLE_CYC = 500; // 20 us of settling at 40 ns
  logic [31:0] q;
  logic pre, oe;
  // ====================
  // Clock, design and host
  always #20 clk_sys = ~clk_sys;
  ssod_top dut (.CLK_SYS(clk_sys), .RST(rst), .PINS(pins), .SLEEP(sleep), .OVERLOAD(ovl), .OVERTEMP(ovt),
    .OUT_ABOVE_THR(thr), .APB_REQ(req), .APB_RSP(rsp), .SO(so), .CHAN_ON(chan_on), .DIAG_CUR_EN(diag_en));
  ssod_host host (.clk(clk_sys), .pins(pins), .so(so));
  // ====================
  // Checks and bus tasks
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit
  // Request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
    req <= {1'b1, 1'b0, w, a, d};
    @(posedge clk_sys) req.penable <= 1'b1;
    do @(posedge clk_sys); while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp_word(r, exp);
    cmp_bit(e, eerr);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic final_report();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // Hang guard, far above the expected run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      bad_count++;
      final_report();
    end
  end
  // ====================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(8'h10, 32'h200, 1'b0);
    rd(8'h00, 32'h0, 1'b0);
    rd(8'h04, 32'h0, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    host.xfer(16, 32'h80a5, q, pre, oe);
    cmp_bit(pre, 1'b1);
    cmp_word(q, 32'h200);
    rd(8'h00, 32'ha5, 1'b0);
    cmp_word({24'h0, chan_on}, 32'ha5);
    host.xfer(24, 32'h3c9112, q, pre, oe);
    cmp_bit(pre, 1'b0);
    cmp_word(q, 32'h3c);
    cmp_word({24'h0, diag_en}, 32'h12);
    // Bad lengths are dropped and flag the error
    foreach (bad_len[i]) begin
      host.xfer(bad_len[i], 32'h8000, q, pre, oe);
      rd(8'h00, 32'ha5, 1'b0);
      rd(8'h10, 32'h200, 1'b0);
    end
    host.xfer(16, 32'h5000, q, pre, oe);
    cmp_bit(pre, 1'b1);
    cmp_word(q, 32'h200);
    // Comparator moves; the status summary follows the OSM snapshot, refreshed only by an OSM read, not by settling
    thr <= 8'h20;
    repeat (SETTLE_CYC) @(posedge clk_sys);
    host.xfer(16, 32'h800f, q, pre, oe);
    cmp_bit(pre, 1'b1);
    cmp_word(q, 32'h20);
    wr(8'h04, 32'h30);
    repeat (SETTLE_CYC) @(posedge clk_sys);
    rd(8'h14, 32'h20, 1'b0);
    rd(8'h10, 32'h100, 1'b0);
    thr <= 8'h01;
    repeat (SETTLE_CYC) @(posedge clk_sys);
    rd(8'h10, 32'h100, 1'b0);
    rd(8'h14, 32'h01, 1'b0);
    rd(8'h10, 32'h0, 1'b0);
    // Latched faults, single and paired channels
    wr(8'h00, 32'hff);
    ovl <= 8'h04;
    repeat (8) @(posedge clk_sys);
    ovl <= 8'h00;
    repeat (4) @(posedge clk_sys);
    cmp_word({24'h0, chan_on}, 32'hfb);
    rd(8'h10, 32'h04, 1'b0);
    wr(8'h08, 32'h04);
    wr(8'h0c, 32'h1);
    cmp_word({24'h0, chan_on}, 32'hff);
    ovt <= 8'h01;
    repeat (8) @(posedge clk_sys);
    ovt <= 8'h00;
    repeat (4) @(posedge clk_sys);
    cmp_word({24'h0, chan_on}, 32'hfc);
    rd(8'h10, 32'h03, 1'b0);
    wr(8'h08, 32'h03);
    rd(8'h10, 32'h0, 1'b0);
    // Sleep blocks the frame; held a while first so the sleep checker sees it
    sleep <= 1'b1;
    repeat (6) @(posedge clk_sys);
    host.xfer(16, 32'h8000, q, pre, oe);
    cmp_bit(oe, 1'b0);
    sleep <= 1'b0;
    rd(8'h00, 32'hff, 1'b0);
    final_report();
  end
endmodule : tb_top
